// >>> inc/xrdma_pkg.sv
// shared constants and types of the external request dma channel
`default_nettype none
package xrdma_pkg;
    // register byte addresses
    localparam logic [31:0] ADDR_SRC = 32'h00fffc80;
    localparam logic [31:0] ADDR_DST = 32'h00fffc84;
    localparam logic [31:0] ADDR_CNT = 32'h00fffc8c;
    localparam logic [31:0] ADDR_MODE = 32'h00fffc94;
    localparam logic [31:0] ADDR_ACTL = 32'h00fffc98;
    localparam logic [31:0] ADDR_STAT = 32'h00fffca0;
    localparam logic [31:0] ADDR_MASK = 32'h00fffca4;
    localparam logic [31:0] ADDR_OFFS = 32'h00fffca8;
    // mode control field positions
    localparam int XFER_EN_BIT = 31;
    localparam int DETECT_SEL_BIT = 27;
    localparam int IRQ_FLAG_BIT = 16;
    localparam int SIZE_LO = 14;
    localparam int MODE_LO = 12;
    localparam int IRQ_EN_BIT = 8;
    localparam int ACT_LO = 6;
    localparam int PRIO_LO = 0;
    // address control field positions
    localparam int ADDR_MODE_BIT = 31;
    localparam int SRC_UPD_LO = 20;
    localparam int DST_UPD_LO = 16;
    // field codes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] ACT_EXT = 2'h3;
    localparam logic [1:0] UPD_FIXED = 2'h0;
    localparam logic [1:0] UPD_OFFSET = 2'h1;
    localparam logic [1:0] UPD_INC = 2'h2;
    localparam logic [1:0] UPD_DEC = 2'h3;
    localparam logic [2:0] PRIO_TOP = 3'h7;
    // values after reset
    localparam logic [31:0] WORD_RST = 32'h00000000;
    localparam logic [1:0] FIELD2_RST = 2'h0;
    localparam logic [2:0] PRIO_RST = 3'h0;
    // channel sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10,
        ST_UPDATE = 2'b11
    } xrdma_state_t;
endpackage
`default_nettype wire

// >>> src/xrdma_req_sync.sv
// synchroniser and falling edge detector for the external request pin
`timescale 1ns/1ps
`default_nettype none
module xrdma_req_sync (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // raw pin, active low
    input wire logic ext_request_n_in,
    // filtered level and edge
    output logic low_out,
    output logic fall_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic stable;
        logic fall;
    } xrdma_sync_t;
    xrdma_sync_t sync_reg;
    xrdma_sync_t sync_next;

    // a level counts only once stages two and three agree
    always_comb begin
        sync_next = sync_reg;
        sync_next.s1 = ext_request_n_in;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        sync_next.fall = 1'b0;
        if (sync_reg.s2 == sync_reg.s3) begin
            sync_next.stable = sync_reg.s2;
            sync_next.fall = sync_reg.stable & ~sync_reg.s2;
        end
    end

    // idle pin is high, so reset to high
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            sync_reg <= 5'h1f & ~5'h01;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign low_out = ~sync_reg.stable;
    assign fall_out = sync_reg.fall;
endmodule // xrdma_req_sync
`default_nettype wire

// >>> src/xrdma_addr_step.sv
// next address after one transfer, per update mode
`timescale 1ns/1ps
`default_nettype none
module xrdma_addr_step (
    // current address and settings
    input wire logic [31:0] addr_in,
    input wire logic [1:0] update_in,
    input wire logic [31:0] step_in,
    input wire logic [31:0] offset_in,
    // result
    output logic [31:0] next_out
);
    // fixed, offset added, increment or decrement by access size
    always_comb begin
        unique case (update_in)
            xrdma_pkg::UPD_FIXED: next_out = addr_in;
            xrdma_pkg::UPD_OFFSET: next_out = addr_in + offset_in;
            xrdma_pkg::UPD_INC: next_out = addr_in + step_in;
            xrdma_pkg::UPD_DEC: next_out = addr_in - step_in;
        endcase
    end
endmodule // xrdma_addr_step
`default_nettype wire

// >>> src/xrdma_channel.sv
// external request dma channel with ahb-lite register slave
// Notes on behaviour
// - transfers happen only while the transfer enable bit is one.
// - detect select bit picks low level (0) or falling edge (1) requests.
// - in edge mode the first transfer after enable starts on a low level.
// - two-bit access size sets access width; 00 means byte accesses.
// - two-bit transfer mode field; 00 means normal transfer mode.
// - interrupt enable bit gates the transfer-end request; zero blocks it.
// - readable writable end flag records a transfer-end request; zero means none.
// - two-bit activation source; 11 means the external request input starts transfers.
// - three-bit priority versus cpu; 111 is level seven, the highest.
// - address mode bit; zero selects dual address, one single address.
// - source update field; 01 adds the offset after each transfer.
// - destination update field; 01 adds the offset after each transfer.
// - each transfer decreases the 32-bit size counter by the access size.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module xrdma_channel (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // external request pin, active low
    input wire logic ext_request_n_in,
    // external bus master side
    output logic bus_request_out,
    output logic [2:0] bus_priority_out,
    output logic mem_read_out,
    output logic mem_write_out,
    output logic mem_single_out,
    output logic [1:0] mem_size_out,
    output logic [31:0] mem_addr_out,
    output logic [31:0] mem_wdata_out,
    input wire logic [31:0] mem_rdata_in,
    input wire logic mem_ack_in,
    // interrupt
    output logic irq_out
);
    typedef struct packed {
        xrdma_pkg::xrdma_state_t state;
        logic en;
        logic sel;
        logic irq_en;
        logic flag;
        logic sgl;
        logic first;
        logic pend;
        logic [1:0] size;
        logic [1:0] mode;
        logic [1:0] act;
        logic [1:0] src_upd;
        logic [1:0] dst_upd;
        logic [2:0] prio;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] cnt;
        logic [31:0] offs;
        logic [31:0] data;
        logic status;
        logic mask;
        logic ph_valid;
        logic ph_wr;
        logic [31:0] ph_addr;
        logic [31:0] hrdata;
        logic irq;
        logic mem_rd;
        logic mem_wr;
        logic [31:0] mem_addr;
        logic busy;
    } xrdma_regs_t;

    xrdma_regs_t r_reg;
    xrdma_regs_t r_next;
    logic req_low;
    logic req_fall;
    logic trigger;
    logic [31:0] step;
    logic [31:0] src_step;
    logic [31:0] dst_step;
    logic [31:0] mode_word;
    logic [31:0] actl_word;

    xrdma_req_sync u_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .ext_request_n_in(ext_request_n_in),
        .low_out(req_low),
        .fall_out(req_fall)
    );

    xrdma_addr_step u_src_step (
        .addr_in(r_reg.src),
        .update_in(r_reg.src_upd),
        .step_in(step),
        .offset_in(r_reg.offs),
        .next_out(src_step)
    );

    xrdma_addr_step u_dst_step (
        .addr_in(r_reg.dst),
        .update_in(r_reg.dst_upd),
        .step_in(step),
        .offset_in(r_reg.offs),
        .next_out(dst_step)
    );

    // bytes per access; byte, word, else long
    always_comb begin
        step = 32'h00000004;
        if (r_reg.size == xrdma_pkg::SIZE_BYTE) begin
            step = 32'h00000001;
        end else if (r_reg.size == xrdma_pkg::SIZE_WORD) begin
            step = 32'h00000002;
        end
    end

    // register images as software sees them
    always_comb begin
        mode_word = 32'h00000000;
        mode_word[xrdma_pkg::XFER_EN_BIT] = r_reg.en;
        mode_word[xrdma_pkg::DETECT_SEL_BIT] = r_reg.sel;
        mode_word[xrdma_pkg::IRQ_FLAG_BIT] = r_reg.flag;
        mode_word[xrdma_pkg::SIZE_LO +: 2] = r_reg.size;
        mode_word[xrdma_pkg::MODE_LO +: 2] = r_reg.mode;
        mode_word[xrdma_pkg::IRQ_EN_BIT] = r_reg.irq_en;
        mode_word[xrdma_pkg::ACT_LO +: 2] = r_reg.act;
        mode_word[xrdma_pkg::PRIO_LO +: 3] = r_reg.prio;
        actl_word = 32'h00000000;
        actl_word[xrdma_pkg::ADDR_MODE_BIT] = r_reg.sgl;
        actl_word[xrdma_pkg::SRC_UPD_LO +: 2] = r_reg.src_upd;
        actl_word[xrdma_pkg::DST_UPD_LO +: 2] = r_reg.dst_upd;
    end

    // other activation codes run as continuous auto request
    always_comb begin
        if (r_reg.act == xrdma_pkg::ACT_EXT) begin
            if (r_reg.sel) begin
                trigger = r_reg.pend | (r_reg.first & req_low);
            end else begin
                trigger = req_low;
            end
        end else begin
            trigger = 1'b1;
        end
    end

    // bus slave, channel sequencer and interrupt in one next-state process
    always_comb begin
        r_next = r_reg;
        r_next.ph_valid = 1'b0;
        // address phase: capture and prefetch read data
        if (hsel_in && htrans_in[1] && hready_in) begin
            r_next.ph_valid = 1'b1;
            r_next.ph_wr = hwrite_in;
            r_next.ph_addr = haddr_in;
            unique case (haddr_in)
                xrdma_pkg::ADDR_SRC: r_next.hrdata = r_reg.src;
                xrdma_pkg::ADDR_DST: r_next.hrdata = r_reg.dst;
                xrdma_pkg::ADDR_CNT: r_next.hrdata = r_reg.cnt;
                xrdma_pkg::ADDR_MODE: r_next.hrdata = mode_word;
                xrdma_pkg::ADDR_ACTL: r_next.hrdata = actl_word;
                xrdma_pkg::ADDR_STAT: r_next.hrdata = {31'h0, r_reg.status};
                xrdma_pkg::ADDR_MASK: r_next.hrdata = {31'h0, r_reg.mask};
                xrdma_pkg::ADDR_OFFS: r_next.hrdata = r_reg.offs;
                default: r_next.hrdata = 32'h00000000;
            endcase
        end
        // data phase write; unmapped addresses are ignored
        if (r_reg.ph_valid && r_reg.ph_wr) begin
            unique case (r_reg.ph_addr)
                xrdma_pkg::ADDR_SRC: r_next.src = hwdata_in;
                xrdma_pkg::ADDR_DST: r_next.dst = hwdata_in;
                xrdma_pkg::ADDR_CNT: r_next.cnt = hwdata_in;
                xrdma_pkg::ADDR_MODE: begin
                    r_next.en = hwdata_in[xrdma_pkg::XFER_EN_BIT];
                    r_next.first = hwdata_in[xrdma_pkg::XFER_EN_BIT] & ~r_reg.en;
                    r_next.pend = 1'b0;
                    r_next.sel = hwdata_in[xrdma_pkg::DETECT_SEL_BIT];
                    // flag only clears by writing zero
                    r_next.flag = r_reg.flag &
                        hwdata_in[xrdma_pkg::IRQ_FLAG_BIT];
                    r_next.size = hwdata_in[xrdma_pkg::SIZE_LO +: 2];
                    r_next.mode = hwdata_in[xrdma_pkg::MODE_LO +: 2];
                    r_next.irq_en = hwdata_in[xrdma_pkg::IRQ_EN_BIT];
                    r_next.act = hwdata_in[xrdma_pkg::ACT_LO +: 2];
                    r_next.prio = hwdata_in[xrdma_pkg::PRIO_LO +: 3];
                end
                xrdma_pkg::ADDR_ACTL: begin
                    r_next.sgl = hwdata_in[xrdma_pkg::ADDR_MODE_BIT];
                    r_next.src_upd = hwdata_in[xrdma_pkg::SRC_UPD_LO +: 2];
                    r_next.dst_upd = hwdata_in[xrdma_pkg::DST_UPD_LO +: 2];
                end
                xrdma_pkg::ADDR_STAT: r_next.status = r_reg.status & ~hwdata_in[0];
                xrdma_pkg::ADDR_MASK: r_next.mask = hwdata_in[0];
                xrdma_pkg::ADDR_OFFS: r_next.offs = hwdata_in;
                default: r_next.offs = r_next.offs;
            endcase
        end
        // a falling edge seen while waiting is kept until served
        if (req_fall) begin
            r_next.pend = 1'b1;
        end
        // sequencer; hardware updates land after the software write
        unique case (r_reg.state)
            xrdma_pkg::ST_IDLE: begin
                if (r_reg.en && r_reg.cnt != 32'h0 && trigger) begin
                    r_next.state = xrdma_pkg::ST_READ;
                    r_next.mem_rd = 1'b1;
                    r_next.mem_addr = r_reg.src;
                    r_next.pend = 1'b0;
                    r_next.first = 1'b0;
                end
            end
            xrdma_pkg::ST_READ: begin
                if (mem_ack_in) begin
                    r_next.data = mem_rdata_in;
                    r_next.mem_rd = 1'b0;
                    if (!r_reg.sgl) begin
                        r_next.state = xrdma_pkg::ST_WRITE;
                        r_next.mem_wr = 1'b1;
                        r_next.mem_addr = r_reg.dst;
                    end else begin
                        r_next.state = xrdma_pkg::ST_UPDATE;
                    end
                end
            end
            xrdma_pkg::ST_WRITE: begin
                if (mem_ack_in) begin
                    r_next.mem_wr = 1'b0;
                    r_next.state = xrdma_pkg::ST_UPDATE;
                end
            end
            xrdma_pkg::ST_UPDATE: begin
                r_next.state = xrdma_pkg::ST_IDLE;
                r_next.src = src_step;
                r_next.dst = dst_step;
                if (r_reg.cnt > step) begin
                    r_next.cnt = r_reg.cnt - step;
                end else begin
                    // count done: flag set wins over a clearing write
                    r_next.cnt = 32'h00000000;
                    r_next.flag = 1'b1;
                    r_next.status = 1'b1;
                    r_next.en = 1'b0;
                end
            end
        endcase
        r_next.busy = (r_next.state != xrdma_pkg::ST_IDLE);
        r_next.irq = (r_reg.flag & r_reg.irq_en) | (r_reg.status & r_reg.mask);
    end

    // control state cleared on reset
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from flops, except hreadyout_out and hresp_out which are tied constant
    assign hrdata_out = r_reg.hrdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign bus_request_out = r_reg.busy;
    assign bus_priority_out = r_reg.prio;
    assign mem_read_out = r_reg.mem_rd;
    assign mem_write_out = r_reg.mem_wr;
    assign mem_single_out = r_reg.sgl;
    assign mem_size_out = r_reg.size;
    assign mem_addr_out = r_reg.mem_addr;
    assign mem_wdata_out = r_reg.data;
    assign irq_out = r_reg.irq;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    chk_idle_when_off: assert property (
        r_reg.state == xrdma_pkg::ST_IDLE && !r_reg.en
        |=> r_reg.state == xrdma_pkg::ST_IDLE)
        else $error("transfer started while disabled");
    chk_level_start: assert property (
        r_reg.state == xrdma_pkg::ST_IDLE && r_reg.en && !r_reg.sel &&
        r_reg.act == xrdma_pkg::ACT_EXT && req_low && r_reg.cnt != 32'h0
        |=> r_reg.state == xrdma_pkg::ST_READ && r_reg.mem_rd)
        else $error("low level request not served");
    chk_first_low: assert property (
        r_reg.state == xrdma_pkg::ST_IDLE && r_reg.en && r_reg.sel &&
        r_reg.first && req_low && r_reg.cnt != 32'h0
        |=> r_reg.state == xrdma_pkg::ST_READ)
        else $error("first edge-mode transfer missed low level");
    chk_ext_wait: assert property (
        r_reg.state == xrdma_pkg::ST_IDLE && r_reg.act == xrdma_pkg::ACT_EXT &&
        !req_low && !r_reg.pend
        |=> r_reg.state == xrdma_pkg::ST_IDLE)
        else $error("external mode started without request");
    chk_count_step: assert property (
        r_reg.state == xrdma_pkg::ST_UPDATE && r_reg.cnt > step
        |=> r_reg.cnt == $past(r_reg.cnt) - $past(step))
        else $error("size counter step wrong");
    chk_end_flag: assert property (
        r_reg.state == xrdma_pkg::ST_UPDATE && r_reg.cnt <= step
        |=> r_reg.flag && !r_reg.en && r_reg.cnt == 32'h0
        ##1 (r_reg.irq == r_reg.irq_en || r_reg.mask))
        else $error("end of count not flagged");
    chk_irq_blocked: assert property (
        (!r_reg.irq_en && !(r_reg.status & r_reg.mask))[*2] |-> !irq_out)
        else $error("interrupt raised while blocked");
    chk_src_offset: assert property (
        r_reg.state == xrdma_pkg::ST_UPDATE &&
        r_reg.src_upd == xrdma_pkg::UPD_OFFSET
        |=> r_reg.src == $past(r_reg.src) + $past(r_reg.offs))
        else $error("source offset not added");
    chk_dst_offset: assert property (
        r_reg.state == xrdma_pkg::ST_UPDATE &&
        r_reg.dst_upd == xrdma_pkg::UPD_OFFSET
        |=> r_reg.dst == $past(r_reg.dst) + $past(r_reg.offs))
        else $error("destination offset not added");
    chk_dual_write: assert property (
        r_reg.state == xrdma_pkg::ST_READ && mem_ack_in && !r_reg.sgl
        |=> mem_write_out && mem_addr_out == $past(r_reg.dst))
        else $error("dual address write missing");
    chk_byte_step: assert property (
        r_reg.state == xrdma_pkg::ST_UPDATE && r_reg.src_upd ==
        xrdma_pkg::UPD_INC && r_reg.size == xrdma_pkg::SIZE_BYTE
        |=> r_reg.src == $past(r_reg.src) + 32'h00000001)
        else $error("byte access step wrong");

    cov_dual_xfer: cover property (
        r_reg.state == xrdma_pkg::ST_WRITE ##1 r_reg.state == xrdma_pkg::ST_UPDATE);
    cov_edge_req: cover property (req_fall ##[1:20] r_reg.mem_rd);
    cov_end_irq: cover property ($rose(irq_out));
endmodule // xrdma_channel
`default_nettype wire

// >>> tb/xrdma_mem_model.sv
// external bus memory areas answering the channel's strobes
`timescale 1ns/1ps
`default_nettype none
module xrdma_mem_model (
    // clock
    input wire logic clock_in,
    // access request from the channel
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [1:0] size_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    // adds wait cycles before each acknowledge
    input wire logic slow_in,
    // answer
    output logic [31:0] rdata_out,
    output logic ack_out
);
    logic [7:0] mem [0:255];
    logic [2:0] wait_reg;
    logic [7:0] a;
    assign a = addr_in[7:0];
    initial begin
        ack_out = 1'b0;
        rdata_out = 32'h0;
        wait_reg = 3'h0;
    end
    // data lines churn outside the ack cycle, so stale reads are seen
    always @(posedge clock_in) begin
        ack_out <= 1'b0;
        rdata_out <= ~rdata_out;
        if ((rd_in || wr_in) && !ack_out) begin
            if (wait_reg < (slow_in ? 3'h3 : 3'h0)) begin
                wait_reg <= wait_reg + 3'h1;
            end else begin
                wait_reg <= 3'h0;
                ack_out <= 1'b1;
                if (rd_in) begin
                    rdata_out <= {mem[8'(a + 3)], mem[8'(a + 2)],
                        mem[8'(a + 1)], mem[a]};
                end
                for (int i = 0; i < 4; i++) begin
                    if (wr_in && i < (1 << size_in)) begin
                        mem[8'(a + i)] <= wdata_in[8 * i +: 8];
                    end
                end
            end
        end
    end
endmodule // xrdma_mem_model
`default_nettype wire

// >>> tb/external_request_dma_channel_tb.sv
// register level bench of the external request dma channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module external_request_dma_channel_tb;
    logic clock_in, rst_n_in, hsel, hwrite, ext_request_n, slow;
    logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata;
    logic [1:0] htrans, mem_size;
    logic hready, mem_read, mem_write, mem_ack, mem_single, irq, busy, hresp;
    logic [2:0] prio;
    int miscompares = 0;
    int num_checks = 0;
    int n_wr = 0;
    int wr_seen = 0;
    xrdma_channel xrdma_channel_inst (.clock_in(clock_in),
        .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp),
        .ext_request_n_in(ext_request_n), .bus_request_out(busy),
        .bus_priority_out(prio), .mem_read_out(mem_read),
        .mem_write_out(mem_write), .mem_single_out(mem_single),
        .mem_size_out(mem_size), .mem_addr_out(mem_addr),
        .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata),
        .mem_ack_in(mem_ack), .irq_out(irq));
    xrdma_mem_model xrdma_mem_model_inst (.clock_in(clock_in),
        .rd_in(mem_read), .wr_in(mem_write), .size_in(mem_size),
        .addr_in(mem_addr), .wdata_in(mem_wdata), .slow_in(slow),
        .rdata_out(mem_rdata), .ack_out(mem_ack));
    // 50 mhz clock
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    // count finished write accesses to spot single address runs
    always @(posedge clock_in) begin
        if (mem_write && mem_ack) n_wr++;
    end
    task automatic print_verdict();
        if (miscompares == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clock_in);
        while (hready !== 1'b1 && n < 20) begin
            @(posedge clock_in);
            n++;
        end
        if (hready !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
    endtask
    // one single ahb-lite transfer, address phase then data phase
    task automatic bus(input logic [31:0] a, input logic w,
        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(a, 1'b1, d, t);
    endtask
    task automatic reg_check(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] t;
        bus(a, 1'b0, 32'h0, t);
        `CHK(t, e)
    endtask
    // polls until the enable bit drops at the end of the run
    task automatic wait_end();
        logic [31:0] t;
        int n;
        n = 0;
        do begin
            bus(xrdma_pkg::ADDR_MODE, 1'b0, 32'h0, t);
            n++;
        end while (t[31] !== 1'b0 && n < 200);
        if (t[31] !== 1'b0) begin
            miscompares++;
            print_verdict();
        end
    endtask
    function automatic logic [31:0] mode(logic en, logic sel,
        logic [1:0] sz, logic ie, logic [2:0] pr);
        mode = 32'h0;
        mode[xrdma_pkg::XFER_EN_BIT] = en;
        mode[xrdma_pkg::DETECT_SEL_BIT] = sel;
        mode[xrdma_pkg::SIZE_LO +: 2] = sz;
        mode[xrdma_pkg::MODE_LO +: 2] = xrdma_pkg::MODE_NORMAL;
        mode[xrdma_pkg::IRQ_EN_BIT] = ie;
        mode[xrdma_pkg::ACT_LO +: 2] = xrdma_pkg::ACT_EXT;
        mode[xrdma_pkg::PRIO_LO +: 3] = pr;
    endfunction
    function automatic logic [31:0] actl(logic sgl, logic [1:0] u);
        actl = 32'h0;
        actl[xrdma_pkg::ADDR_MODE_BIT] = sgl;
        actl[xrdma_pkg::SRC_UPD_LO +: 2] = u;
        actl[xrdma_pkg::DST_UPD_LO +: 2] = u;
    endfunction
    // cuts a hang short
    initial begin
        repeat (60000) @(posedge clock_in);
        miscompares++;
        print_verdict();
    end
    initial begin
        rst_n_in = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        ext_request_n = 1'b1;
        slow = 1'b0;
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        // values after reset and an unmapped place
        reg_check(xrdma_pkg::ADDR_MODE, 32'h0);
        reg_check(xrdma_pkg::ADDR_ACTL, 32'h0);
        reg_check(32'h00fffcf0, 32'h0);
        `CHK(hresp, 1'b0)
        // level mode, byte size, offset updates, end interrupt enabled
        xrdma_mem_model_inst.mem[8'h10] = 8'ha5;
        xrdma_mem_model_inst.mem[8'h14] = 8'h5a;
        reg_write(xrdma_pkg::ADDR_SRC, 32'h10);
        reg_write(xrdma_pkg::ADDR_DST, 32'h40);
        reg_write(xrdma_pkg::ADDR_OFFS, 32'h4);
        reg_write(xrdma_pkg::ADDR_CNT, 32'h2);
        reg_write(xrdma_pkg::ADDR_ACTL, actl(1'b0, xrdma_pkg::UPD_OFFSET));
        reg_write(xrdma_pkg::ADDR_MODE, mode(0, 0, 2'h0, 1, 3'h7));
        reg_check(xrdma_pkg::ADDR_MODE, mode(0, 0, 2'h0, 1, 3'h7));
        ext_request_n <= 1'b0;
        repeat (20) @(posedge clock_in);
        `CHK(mem_read, 1'b0)
        `CHK(prio, xrdma_pkg::PRIO_TOP)
        reg_write(xrdma_pkg::ADDR_MODE, mode(1, 0, 2'h0, 1, 3'h7));
        wait_end();
        `CHK(xrdma_mem_model_inst.mem[8'h40], 8'ha5)
        `CHK(xrdma_mem_model_inst.mem[8'h44], 8'h5a)
        reg_check(xrdma_pkg::ADDR_SRC, 32'h18);
        reg_check(xrdma_pkg::ADDR_DST, 32'h48);
        reg_check(xrdma_pkg::ADDR_CNT, 32'h0);
        `CHK(irq, 1'b1)
        reg_check(xrdma_pkg::ADDR_MODE,
            mode(0, 0, 2'h0, 1, 3'h7) | 32'h00010000);
        reg_check(xrdma_pkg::ADDR_STAT, 32'h1);
        // clearing the end flag by writing zero drops the request
        reg_write(xrdma_pkg::ADDR_MODE, mode(0, 0, 2'h0, 1, 3'h7));
        repeat (2) @(posedge clock_in);
        `CHK(irq, 1'b0)
        reg_write(xrdma_pkg::ADDR_MASK, 32'h1);
        repeat (2) @(posedge clock_in);
        `CHK(irq, 1'b1)
        reg_write(xrdma_pkg::ADDR_STAT, 32'h1);
        repeat (2) @(posedge clock_in);
        `CHK(irq, 1'b0)
        reg_write(xrdma_pkg::ADDR_MASK, 32'h0);
        // edge mode with the pin already low: first one goes on level
        reg_write(xrdma_pkg::ADDR_SRC, 32'h10);
        reg_write(xrdma_pkg::ADDR_DST, 32'h80);
        reg_write(xrdma_pkg::ADDR_CNT, 32'h2);
        reg_write(xrdma_pkg::ADDR_MODE, mode(1, 1, 2'h0, 0, 3'h5));
        repeat (3) @(posedge clock_in);
        `CHK(busy, 1'b1)
        repeat (37) @(posedge clock_in);
        `CHK(busy, 1'b0)
        reg_check(xrdma_pkg::ADDR_CNT, 32'h1);
        `CHK(prio, 3'h5)
        ext_request_n <= 1'b1;
        repeat (10) @(posedge clock_in);
        ext_request_n <= 1'b0;
        wait_end();
        `CHK(xrdma_mem_model_inst.mem[8'h84], 8'h5a)
        `CHK(irq, 1'b0)
        reg_check(xrdma_pkg::ADDR_MODE,
            mode(0, 1, 2'h0, 0, 3'h5) | 32'h00010000);
        // word accesses with a slow memory, size stepped addresses
        slow <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            xrdma_mem_model_inst.mem[8'(8'h20 + i)] = 8'(8'h11 * (i + 1));
        end
        reg_write(xrdma_pkg::ADDR_SRC, 32'h20);
        reg_write(xrdma_pkg::ADDR_DST, 32'h60);
        reg_write(xrdma_pkg::ADDR_CNT, 32'h4);
        reg_write(xrdma_pkg::ADDR_ACTL, actl(1'b0, xrdma_pkg::UPD_INC));
        reg_write(xrdma_pkg::ADDR_MODE, mode(1, 0, 2'h1, 0, 3'h7));
        wait_end();
        `CHK({xrdma_mem_model_inst.mem[8'h63], xrdma_mem_model_inst.mem[8'h62],
            xrdma_mem_model_inst.mem[8'h61], xrdma_mem_model_inst.mem[8'h60]},
            32'h44332211)
        reg_check(xrdma_pkg::ADDR_SRC, 32'h24);
        reg_check(xrdma_pkg::ADDR_CNT, 32'h0);
        // single address mode reads only; pin released, code 00 runs on its own
        ext_request_n <= 1'b1;
        reg_write(xrdma_pkg::ADDR_ACTL, actl(1'b1, xrdma_pkg::UPD_INC));
        reg_write(xrdma_pkg::ADDR_CNT, 32'h1);
        `CHK(mem_single, 1'b1)
        wr_seen = n_wr;
        reg_write(xrdma_pkg::ADDR_MODE,
            mode(1, 0, 2'h0, 0, 3'h7) & ~32'h000000c0);
        wait_end();
        `CHK(n_wr, wr_seen)
        reg_check(xrdma_pkg::ADDR_SRC, 32'h25);
        print_verdict();
    end
endmodule // external_request_dma_channel_tb
`default_nettype wire
